/* core/irq_map_pkg.sv */
// shared constants for the interrupt request map and level resolver
package irq_map_pkg;

  // request line and level field geometry
  localparam int NUM_REQ = 24;
  localparam int REQ_IDX_W = 5;
  localparam int LEVEL_W = 2;
  localparam int FIELDS_PER_REG = 4;
  localparam int NUM_LEVEL_REGS = 6;
  localparam int LEVEL_REG_W = 8;
  localparam int LEVEL_REG_IDX_W = 3;
  localparam int VEC_ADDR_W = 16;

  // every level register comes out of reset at the lowest priority
  localparam logic [LEVEL_REG_W-1:0] LEVEL_RESET = 8'hff;
  localparam logic [LEVEL_W-1:0] LEVEL_LOWEST = 2'h3;

  // vector table: request 0 upper byte at the top, each next request two bytes down
  localparam logic [VEC_ADDR_W-1:0] VECTOR_BASE = 16'hfffa;

  // request line of each source
  localparam int REQ_EXT4 = 0;
  localparam int REQ_EXT5 = 1;
  localparam int REQ_EXT2_6 = 2;
  localparam int REQ_EXT3_7 = 3;
  localparam int REQ_TMR0_LOWER = 5;
  localparam int REQ_TMR0_UPPER = 6;
  localparam int REQ_SERIAL_RX = 7;
  localparam int REQ_SERIAL_TX = 8;
  localparam int REQ_TMR1_UPPER = 14;
  localparam int REQ_ADC = 18;
  localparam int REQ_TIMEBASE = 19;
  localparam int REQ_WATCH = 20;
  localparam int REQ_TMR1_LOWER = 22;
  localparam int REQ_FLASH = 23;

  // lines that have a source behind them; the rest are held low
  localparam logic [NUM_REQ-1:0] ASSIGNED_MASK = 24'hdc41ef;

endpackage

/* core/irq_level_if.sv */
// carrier between the request map and the priority resolver
`timescale 1ns/1ps
interface irq_level_if;
  logic [irq_map_pkg::NUM_REQ-1:0] req;
  logic [irq_map_pkg::NUM_REQ-1:0][irq_map_pkg::LEVEL_W-1:0] level;
  logic win_valid;
  logic [irq_map_pkg::REQ_IDX_W-1:0] win_index;
  logic [irq_map_pkg::LEVEL_W-1:0] win_level;

  modport owner (output req, output level, input win_valid, input win_index, input win_level);
  modport resolver (input req, input level, output win_valid, output win_index, output win_level);
endinterface

/* core/irq_priority_resolver.sv */
// combinational pick of the most urgent pending request
`timescale 1ns/1ps
module irq_priority_resolver (
  irq_level_if.resolver bus
);

  // lowest level value wins; strict compare keeps the lower line on a tie
  always_comb begin
    bus.win_valid = 1'b0;
    bus.win_index = '0;
    bus.win_level = irq_map_pkg::LEVEL_LOWEST;
    for (int i = 0; i < irq_map_pkg::NUM_REQ; i++) begin
      if (bus.req[i] && (!bus.win_valid || (bus.level[i] < bus.win_level))) begin
        bus.win_valid = 1'b1;
        bus.win_index = irq_map_pkg::REQ_IDX_W'(i);
        bus.win_level = bus.level[i];
      end
    end
  end

endmodule

/* core/interrupt_vector_priority_map.sv */
// interrupt request map, level registers and vector address output
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module interrupt_vector_priority_map (
  input wire logic sys_clk,
  input wire logic reset_n,
  // peripheral requests, levels synchronous to sys_clk
  input wire logic [7:0] ext_int_req,
  input wire logic timer0_lower_req,
  input wire logic timer0_upper_req,
  input wire logic timer1_lower_req,
  input wire logic timer1_upper_req,
  input wire logic serial_rx_req,
  input wire logic serial_tx_req,
  input wire logic adc_req,
  input wire logic timebase_req,
  input wire logic watch_prescaler_req,
  input wire logic flash_req,
  // level register access
  input wire logic level_wr_en,
  input wire logic [irq_map_pkg::LEVEL_REG_IDX_W-1:0] level_wr_index,
  input wire logic [irq_map_pkg::LEVEL_REG_W-1:0] level_wr_data,
  input wire logic [irq_map_pkg::LEVEL_REG_IDX_W-1:0] level_rd_index,
  output logic [irq_map_pkg::LEVEL_REG_W-1:0] level_rd_data,
  // toward the cpu core
  output logic irq_request,
  output logic [irq_map_pkg::REQ_IDX_W-1:0] irq_number,
  output logic [irq_map_pkg::LEVEL_W-1:0] irq_level,
  output logic [irq_map_pkg::VEC_ADDR_W-1:0] vector_upper_addr,
  output logic [irq_map_pkg::VEC_ADDR_W-1:0] vector_lower_addr
);

  typedef logic [irq_map_pkg::NUM_LEVEL_REGS-1:0][irq_map_pkg::LEVEL_REG_W-1:0] level_file_t;

  typedef struct packed {
    level_file_t level_regs;
    logic [irq_map_pkg::LEVEL_REG_W-1:0] rd_data;
    logic pending;
    logic [irq_map_pkg::REQ_IDX_W-1:0] number;
    logic [irq_map_pkg::LEVEL_W-1:0] level;
    logic [irq_map_pkg::VEC_ADDR_W-1:0] vec_upper;
    logic [irq_map_pkg::VEC_ADDR_W-1:0] vec_lower;
  } state_t;

  state_t state;
  state_t next_state;
  logic [irq_map_pkg::NUM_REQ-1:0] raw_req;
  logic [irq_map_pkg::VEC_ADDR_W-1:0] win_offset;

  irq_level_if lvl_bus ();

  //////////////////////////////////////////////////////////////////////////////
  // source to request line wiring

  // shared external lines are a plain or; the handler must poll both channels
  always_comb begin
    raw_req = '0;
    raw_req[irq_map_pkg::REQ_EXT4] = ext_int_req[4];
    raw_req[irq_map_pkg::REQ_EXT5] = ext_int_req[5];
    raw_req[irq_map_pkg::REQ_EXT2_6] = ext_int_req[2] | ext_int_req[6];
    raw_req[irq_map_pkg::REQ_EXT3_7] = ext_int_req[3] | ext_int_req[7];
    raw_req[irq_map_pkg::REQ_TMR0_LOWER] = timer0_lower_req;
    raw_req[irq_map_pkg::REQ_TMR0_UPPER] = timer0_upper_req;
    raw_req[irq_map_pkg::REQ_TMR1_UPPER] = timer1_upper_req;
    raw_req[irq_map_pkg::REQ_TMR1_LOWER] = timer1_lower_req;
    raw_req[irq_map_pkg::REQ_SERIAL_RX] = serial_rx_req;
    raw_req[irq_map_pkg::REQ_SERIAL_TX] = serial_tx_req;
    raw_req[irq_map_pkg::REQ_ADC] = adc_req;
    raw_req[irq_map_pkg::REQ_TIMEBASE] = timebase_req;
    raw_req[irq_map_pkg::REQ_WATCH] = watch_prescaler_req;
    raw_req[irq_map_pkg::REQ_FLASH] = flash_req;
  end

  // unassigned lines forced low, so no stray source can ever win
  assign lvl_bus.req = raw_req & irq_map_pkg::ASSIGNED_MASK;

  //////////////////////////////////////////////////////////////////////////////
  // per line level field, four 2-bit fields to a register, lowest line lowest bits

  // every line keeps a field, assigned or not, so the layout stays regular
  for (genvar g = 0; g < irq_map_pkg::NUM_REQ; g++) begin : g_level_field
    localparam int REG_SEL = g / irq_map_pkg::FIELDS_PER_REG;
    localparam int BIT_LO = (g % irq_map_pkg::FIELDS_PER_REG) * irq_map_pkg::LEVEL_W;
    assign lvl_bus.level[g] = state.level_regs[REG_SEL][BIT_LO +: irq_map_pkg::LEVEL_W];
  end

  irq_priority_resolver u_resolver (
    .bus(lvl_bus)
  );

  // vector upper byte address steps down two bytes per line from the top slot
  assign win_offset = {{(irq_map_pkg::VEC_ADDR_W - irq_map_pkg::REQ_IDX_W - 1){1'b0}},
                       lvl_bus.win_index, 1'b0};

  //////////////////////////////////////////////////////////////////////////////
  // next state

  // levels are taken from registers, so a level write shows one cycle later
  always_comb begin
    next_state = state;
    if (level_wr_en &&
        (level_wr_index < irq_map_pkg::LEVEL_REG_IDX_W'(irq_map_pkg::NUM_LEVEL_REGS))) begin
      next_state.level_regs[level_wr_index] = level_wr_data;
    end
    // out of range read returns zero rather than a stale word
    if (level_rd_index < irq_map_pkg::LEVEL_REG_IDX_W'(irq_map_pkg::NUM_LEVEL_REGS)) begin
      next_state.rd_data = state.level_regs[level_rd_index];
    end else begin
      next_state.rd_data = '0;
    end
    next_state.pending = lvl_bus.win_valid;
    next_state.number = lvl_bus.win_index;
    next_state.level = lvl_bus.win_level;
    next_state.vec_upper = irq_map_pkg::VECTOR_BASE - win_offset;
    next_state.vec_lower = (irq_map_pkg::VECTOR_BASE - win_offset) | 16'h0001;
    // with nothing pending the outputs park on a clean idle value
    if (!lvl_bus.win_valid) begin
      next_state.number = '0;
      next_state.level = irq_map_pkg::LEVEL_LOWEST;
      next_state.vec_upper = '0;
      next_state.vec_lower = '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  // synchronous reset: all levels to the lowest priority
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= '0;
      state.level_regs <= {irq_map_pkg::NUM_LEVEL_REGS{irq_map_pkg::LEVEL_RESET}};
      state.level <= irq_map_pkg::LEVEL_LOWEST;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register

  assign level_rd_data = state.rd_data;
  assign irq_request = state.pending;
  assign irq_number = state.number;
  assign irq_level = state.level;
  assign vector_upper_addr = state.vec_upper;
  assign vector_lower_addr = state.vec_lower;

endmodule

/* verification/irq_map_assertions.sv */
// port-level checks for the interrupt vector map
`timescale 1ns/1ps
module irq_map_assertions (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] ext_int_req,
  input wire logic flash_req,
  input wire logic level_wr_en,
  input wire logic [2:0] level_wr_index,
  input wire logic [7:0] level_wr_data,
  input wire logic [2:0] level_rd_index,
  input wire logic [7:0] level_rd_data,
  input wire logic irq_request,
  input wire logic [4:0] irq_number,
  input wire logic [1:0] irq_level,
  input wire logic [15:0] vector_upper_addr,
  input wire logic [15:0] vector_lower_addr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // winner, vector and source must agree; the winner comes from last edge's inputs
  vec_pair_a: assert property (irq_request |-> vector_lower_addr == vector_upper_addr + 16'h1)
    else $error("lower vector byte not next to upper");
  vec_base_a: assert property (irq_request |->
    vector_upper_addr == 16'hfffa - {10'h0, irq_number, 1'b0})
    else $error("vector slot does not match request line");
  ext4_line_a: assert property (irq_request && irq_number == 5'h0 |->
    $past(ext_int_req[4]))
    else $error("line 0 won without channel 4");
  shared_line_a: assert property (irq_request && irq_number == 5'h2 |->
    $past(ext_int_req[2] | ext_int_req[6]))
    else $error("line 2 won without channel 2 or 6");
  flash_line_a: assert property (irq_request && irq_number == 5'h17 |->
    $past(flash_req))
    else $error("line 23 won without flash request");
  empty_slot_a: assert property (irq_request |-> irq_map_pkg::ASSIGNED_MASK[irq_number])
    else $error("line without a source won");
  // reset must leave idle outputs and all-ones levels
  reset_idle_a: assert property (disable iff (1'b0)
    !reset_n |=> !irq_request && irq_level == 2'h3)
    else $error("outputs not idle after reset");
  reset_level_a: assert property (disable iff (1'b0)
    !reset_n ##1 reset_n && level_rd_index < 3'h6 |=> level_rd_data == 8'hff)
    else $error("level register not all ones after reset");
  wr_read_a: assert property (level_wr_en && level_wr_index < 3'h6
    ##1 level_rd_index == $past(level_wr_index)
    |=> level_rd_data == $past(level_wr_data, 2))
    else $error("level readback differs from write");
  bad_index_a: assert property (level_rd_index > 3'h5 |=> level_rd_data == 8'h00)
    else $error("unused level index read nonzero");
  // main scenarios
  cover property (irq_request && irq_number == 5'h17);
  cover property (level_wr_en && level_wr_index > 3'h5);
  cover property ($fell(irq_request));
endmodule

/* verification/vector_fetch_model.sv */
// cpu side model that latches the vector byte pair it would fetch
`timescale 1ns/1ps
module vector_fetch_model (
  input wire logic sys_clk,
  input wire logic stall,
  input wire logic irq_request,
  input wire logic [15:0] vector_upper_addr,
  input wire logic [15:0] vector_lower_addr,
  output logic [31:0] fetch_addr
);
  // a stalled core defers acceptance and keeps the previous fetch
  always_ff @(posedge sys_clk) begin
    if (irq_request && !stall) begin
      fetch_addr <= {vector_upper_addr, vector_lower_addr};
    end
  end
endmodule

/* verification/tb_interrupt_vector_priority_map.sv */
// self-checking bench for the interrupt vector map
`timescale 1ns/1ps
module tb_interrupt_vector_priority_map;
  logic sys_clk, reset_n, level_wr_en, stall;
  logic [17:0] src;
  logic [2:0] level_wr_index, level_rd_index;
  logic [7:0] level_wr_data, level_rd_data;
  logic irq_request;
  logic [4:0] irq_number;
  logic [1:0] irq_level;
  logic [15:0] vector_upper_addr, vector_lower_addr;
  logic [31:0] fetch, last_fetch;
  logic [7:0] lv [8];
  int err_count, n_tests, bl, bn, ln, lf;
  // request line of each source bit; 24 means no line
  int line_of [18] = '{24, 24, 2, 3, 0, 1, 2, 3, 5, 6, 14, 22, 7, 8, 18, 19, 20, 23};
  interrupt_vector_priority_map u_interrupt_vector_priority_map (.sys_clk, .reset_n,
    .ext_int_req(src[7:0]), .timer0_lower_req(src[8]), .timer0_upper_req(src[9]),
    .timer1_upper_req(src[10]), .timer1_lower_req(src[11]), .serial_rx_req(src[12]),
    .serial_tx_req(src[13]), .adc_req(src[14]), .timebase_req(src[15]),
    .watch_prescaler_req(src[16]), .flash_req(src[17]), .level_wr_en, .level_wr_index,
    .level_wr_data, .level_rd_index, .level_rd_data, .irq_request, .irq_number, .irq_level,
    .vector_upper_addr, .vector_lower_addr);
  vector_fetch_model u_vector_fetch_model (.sys_clk, .stall, .irq_request, .vector_upper_addr,
    .vector_lower_addr, .fetch_addr(fetch));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one pattern plus one level write; stall only opens at the last edge so the
  // model never catches the half-settled winner of the old levels
  task automatic step(input logic [17:0] s, input logic [2:0] wi, input logic [7:0] wd,
                      input logic st);
    @(posedge sys_clk);
    #2 {src, level_wr_en, level_wr_index, level_wr_data, level_rd_index, stall} =
      {s, 1'b1, wi, wd, wi, 1'b1};
    @(posedge sys_clk);
    #2 level_wr_en = 1'b0;
    if (wi < 3'h6) lv[wi] = wd;
    @(posedge sys_clk);
    #2 stall = st;
    {bl, bn} = {32'd4, 32'd0};
    for (int i = 0; i < 18; i++) begin
      ln = line_of[i];
      lf = (ln < 24) ? lv[ln / 4][2 * (ln % 4) +: 2] : 4;
      if (s[i] && (lf < bl || (lf == bl && ln < bn))) {bl, bn} = {lf, ln};
    end
    chk("request", irq_request, bl < 4);
    chk("number", irq_number, bl < 4 ? bn : 0);
    chk("level", irq_level, bl < 4 ? bl : 3);
    chk("upper", vector_upper_addr, bl < 4 ? 16'hfffa - 2 * bn : 0);
    chk("lower", vector_lower_addr, bl < 4 ? 16'hfffb - 2 * bn : 0);
    chk("readback", level_rd_data, lv[wi]);
    @(posedge sys_clk);
    #2 if (bl < 4 && !st) last_fetch = {16'(16'hfffa - 2 * bn), 16'(16'hfffb - 2 * bn)};
    chk("fetch", fetch, last_fetch);
  endtask
  // free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // main sequence
  initial begin
    {reset_n, level_wr_en, stall, src, level_wr_index, level_wr_data, level_rd_index} = '0;
    {err_count, n_tests} = '0;
    lv = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
    void'($urandom(25));
    repeat (20) @(posedge sys_clk);
    #2 reset_n = 1'b1;
    for (int r = 0; r < 8; r++) begin
      level_rd_index = 3'(r);
      @(posedge sys_clk);
      #2 chk("reset level", level_rd_data, lv[r]);
    end
    $display("reset test done");
    step(18'h3fffc, 3'h6, 8'h00, 1'b0);
    step(18'h00003, 3'h5, 8'h3f, 1'b0);
    step(18'h3ffff, 3'h0, 8'h00, 1'b1);
    step(18'h20044, 3'h0, 8'hff, 1'b0);
    $display("corner test done");
    for (int i = 0; i < 18; i++) step(18'h1 << i, 3'($urandom), 8'($urandom), 1'b0);
    $display("source test done");
    repeat (300) step(18'($urandom), 3'($urandom), 8'($urandom), 1'($urandom));
    $display("random test done");
    final_report();
  end
endmodule
bind interrupt_vector_priority_map irq_map_assertions u_irq_map_assertions (.sys_clk, .reset_n,
  .ext_int_req, .flash_req, .level_wr_en, .level_wr_index, .level_wr_data, .level_rd_index,
  .level_rd_data, .irq_request, .irq_number, .irq_level, .vector_upper_addr, .vector_lower_addr);
